// ==== pkg/nbps_pkg.sv ====
// nbps_pkg: constants, encodings and carriers of the boot probe sequencer
// assumes a 100 MHz system clock and byte-wide memory access engines
package nbps_pkg;

  //////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLOCK_MHZ       = 100;
  localparam int unsigned RESP_TIMEOUT_US = 100;  // per byte request
  localparam int unsigned PROBE_BUDGET_MS = 900;  // total pin drive
  localparam int unsigned RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLOCK_MHZ;
  localparam int unsigned PROBE_BUDGET_CYC =
    PROBE_BUDGET_MS * CLOCK_MHZ * 1000;

  //////////////////////////////////////////////////////////////////////
  // nand header, parameter page and code location
  localparam logic [3:0]  HDR_KEY        = 4'hC;
  localparam logic [1:0]  HDR_SECT_1024  = 2'h1;
  localparam logic [7:0]  NAND_ID_OPCODE = 8'h90;
  localparam logic [15:0] NAND_ID_ADDR   = 16'h0020;
  localparam logic [31:0] ONFI_SIG       = 32'h4946_4E4F;
  localparam logic [15:0] PP_PAGE_OFS    = 16'h0050;  // byte 80
  localparam logic [15:0] PP_SPARE_OFS   = 16'h0054;  // byte 84
  localparam logic [15:0] PP_ECC_OFS     = 16'h0070;  // byte 112
  localparam logic [7:0]  ECC_CAP_WIDE   = 8'hFF;
  localparam logic [10:0] SECT_512       = 11'h200;
  localparam logic [10:0] SECT_1024      = 11'h400;
  localparam logic [15:0] NAND_CODE_OFS  = 16'h00D0;

  //////////////////////////////////////////////////////////////////////
  // exception vector check
  localparam logic [15:0] VEC_BYTES   = 16'h001C;  // 28 bytes
  localparam logic [15:0] VEC6_OFS    = 16'h0014;
  localparam logic [31:0] IMG_MAX     = 32'h0000_6000;  // 24 Kbytes
  localparam logic [31:0] BRANCH_MASK = 32'hFF00_0000;
  localparam logic [31:0] BRANCH_OPC  = 32'hEA00_0000;
  localparam logic [31:0] LDR_MASK    = 32'hFF7F_F000;
  localparam logic [31:0] LDR_OPC     = 32'hE51F_F000;

  //////////////////////////////////////////////////////////////////////
  // serial sources and rom vector
  localparam logic [7:0]  SPI_OP_GENERIC   = 8'h0B;
  localparam logic [7:0]  SPI_OP_PAGED     = 8'hE8;
  localparam logic [6:0]  EEPROM_DEV_ADDR  = 7'h50;
  localparam logic [31:0] ROM_ECC_VEC_ADDR = 32'h0010_0008;

  // port groups whose pins may be driven
  localparam int unsigned PORT_SPI = 0;
  localparam int unsigned PORT_SD  = 1;
  localparam int unsigned PORT_NAND = 2;
  localparam int unsigned PORT_TWI = 3;
  localparam int unsigned PORT_MON = 4;

  typedef enum logic [2:0] {
    SRC_SPI_GENERIC = 3'h0, SRC_SPI_PAGED = 3'h1, SRC_SD = 3'h2,
    SRC_NAND = 3'h3, SRC_TWI = 3'h4
  } nbps_src_e;

  typedef enum logic [1:0] {
    OP_READ = 2'h0, OP_ID = 2'h1, OP_PARAM = 2'h2, OP_FILE = 2'h3
  } nbps_op_e;

  typedef enum logic [1:0] {
    IF_NONE = 2'h0, IF_USB = 2'h1, IF_DEBUG_SERIAL = 2'h2
  } nbps_iface_e;

  // byte read request toward the memory engines
  typedef struct packed {
    logic        valid;
    nbps_src_e   src;
    nbps_op_e    op;
    logic [7:0]  opcode;
    logic [15:0] addr;
    logic        useEccFlag;
    logic [10:0] eccSector;
    logic [6:0]  devAddr;
  } nbps_req_s;

  // one byte answer from the engines
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } nbps_rsp_s;

  // write into internal sram
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } nbps_sram_s;

endpackage

// ==== logic/nbps_sequencer.sv ====
// nbps_sequencer: probes boot memories in turn and copies valid code
// assumes byte engines for each memory port and an sram write port
//
// Notes on behaviour
// - nand header word accepted only when its top nibble is 0xC.
// - first 28 bytes are seven vectors; all but sixth branch or load pc.
// - sixth vector at 0x14 is image length, below 24 Kbytes.
// - failed or empty memory: release its pins, reset it, try next.
// - no header: nand id opcode 0x90 with address 0x20.
// - parameter page gives page 80, spare 84, ecc bits 112.
// - ecc sector 512 bytes, 1024 when ecc capability reads 0xFF.
// - parameter page discovery forces ecc use on.
// - reread first page, code checked from 0xD0, copied to sram start.
// - only 8-bit nand is read.
// - header ecc flag clear means page reads without ecc.
// - ecc routine entry lives at rom vector 0x100008.
// - sd card via card host 0, boot.bin in fat root.
// - sd cards of spec v2.0 including high capacity accepted.
// - spi port 0 select 0, generic flash first, then paged.
// - spi and eeprom checked by vectors only.
// - spi continuous read from 0; 0xE8 paged, 0x0B generic.
// - paged flash of 264, 528 or 1056 byte pages handled.
// - eeprom on two-wire port 0, device address 0x50.
// - without valid image, pins driven under one second in total.
// - all used pins and ports reset before the jump.
// - no code anywhere: monitor starts, picks usb or debug serial.
// - monitor loops forever once its interface is chosen.
`timescale 1ns/1ps
module nbps_sequencer
  import nbps_pkg::*;
#(
  parameter int unsigned RESP_TIMEOUT = RESP_TIMEOUT_CYC,
  parameter int unsigned PROBE_BUDGET = PROBE_BUDGET_CYC
) (
  input  wire logic        clock,          // system clock
  input  wire logic        rst,            // synchronous reset
  output nbps_req_s        memReq,         // byte read request
  input  wire nbps_rsp_s   memRsp,         // byte answer
  output logic             sramValid,      // sram byte offered
  output nbps_sram_s       sramWr,         // sram address and byte
  input  wire logic        sramReady,      // sram takes the byte
  output logic [4:0]       pinDrive,       // port pins in use
  output logic [4:0]       portReset,      // port back to reset
  input  wire logic        usbEnumerated,  // usb enumeration seen
  input  wire logic        debugRxSeen,    // debug serial char seen
  output logic             monitorInit,    // monitor ports started
  output logic             monitorRun,     // monitor command loop
  output nbps_iface_e      monitorIface,   // chosen monitor link
  output logic             bootDone,       // jump to sram code
  output logic [31:0]      eccVecAddr      // rom ecc routine vector
);

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_SETUP   = 4'h1,
    S_HDR     = 4'h3,
    S_ID      = 4'h2,
    S_PARAM   = 4'h6,
    S_VEC     = 4'h7,
    S_COPY    = 4'h5,
    S_DRAIN   = 4'h4,
    S_RELEASE = 4'hC,
    S_JUMP    = 4'hD,
    S_RESTORE = 4'hF,
    S_MON     = 4'hE,
    S_LOOP    = 4'hA
  } nbps_state_e;

  typedef struct packed {
    nbps_state_e       st;
    nbps_src_e         src;
    logic [15:0]       cnt;
    logic [15:0]       base;
    logic [31:0]       word;
    logic [15:0]       imgLen;
    logic              useEccFlag;
    logic              sect1024;
    logic [15:0]       pageSize;
    logic [15:0]       spareSize;
    logic [7:0]        eccBits;
    logic [31:0]       waitCnt;
    logic [31:0]       budget;
    logic              giveUp;
    logic [1:0]        usbSync;
    logic [1:0]        dbgSync;
    nbps_iface_e       iface;
    logic [1:0]        fill;
    nbps_sram_s [1:0]  buffer;
  } nbps_regs_s;

  nbps_regs_s  r;
  nbps_regs_s  next_r;
  logic        got;
  logic        lastByte;
  logic        probing;
  logic        reading;
  logic        vecBad;
  logic        pop;
  logic        push;
  logic [1:0]  fillAfterPop;
  logic [31:0] word;

  // map a source to the group of pins it drives
  function automatic int unsigned portOf(nbps_src_e s);
    unique case (s)
      SRC_SPI_GENERIC, SRC_SPI_PAGED: portOf = PORT_SPI;
      SRC_SD:   portOf = PORT_SD;
      SRC_NAND: portOf = PORT_NAND;
      default:  portOf = PORT_TWI;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // request toward the memory engines
  always_comb begin
    memReq            = '0;
    memReq.src        = r.src;
    memReq.useEccFlag = r.useEccFlag;
    memReq.eccSector  = r.sect1024 ? SECT_1024 : SECT_512;
    memReq.devAddr    = EEPROM_DEV_ADDR;
    memReq.opcode     = (r.src == SRC_SPI_PAGED) ? SPI_OP_PAGED
                                                 : SPI_OP_GENERIC;
    // the address stays linear for every source; a paged flash engine
    // splits it into page and offset for its own page size
    memReq.addr       = r.base + r.cnt;
    memReq.op         = OP_READ;
    unique case (r.st)
      S_HDR, S_VEC: memReq.valid = 1'b1;
      S_ID: begin
        memReq.valid  = 1'b1;
        memReq.op     = OP_ID;
        memReq.opcode = NAND_ID_OPCODE;
        memReq.addr   = NAND_ID_ADDR;
      end
      S_PARAM: begin
        memReq.valid = 1'b1;
        memReq.op    = OP_PARAM;
      end
      S_COPY: memReq.valid = (r.cnt != r.imgLen) && (r.fill != 2'h2);
      default: memReq.valid = 1'b0;
    endcase
    // sd engine resolves boot.bin on a fat root, v2.0 and sdhc
    if (r.src == SRC_SD && memReq.op == OP_READ) begin
      memReq.op = OP_FILE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // next state of the sequencer, buffer and synchronisers
  always_comb begin
    next_r   = r;
    got      = memReq.valid && memRsp.valid;
    word     = {memRsp.data, r.word[31:8]};  // 8-bit bus only
    lastByte = (r.cnt[1:0] == 2'h3);
    reading  = r.st inside {S_HDR, S_ID, S_PARAM, S_VEC, S_COPY};
    probing  = reading || r.st inside {S_SETUP, S_DRAIN};
    vecBad   = 1'b0;

    next_r.usbSync = {r.usbSync[0], usbEnumerated};
    next_r.dbgSync = {r.dbgSync[0], debugRxSeen};

    // two-entry buffer toward sram
    // a pop and a push may share a cycle; the push lands in the slot
    // left after the pop, so a stalled sram never loses a byte and the
    // request is only withheld while both slots are full
    pop          = (r.fill != 2'h0) && sramReady;
    push         = got && (r.st == S_COPY);
    fillAfterPop = r.fill - {1'b0, pop};
    if (pop) begin
      next_r.buffer[0] = r.buffer[1];
    end
    if (push) begin
      next_r.buffer[fillAfterPop[0]] = {r.cnt[14:0], memRsp.data};
    end
    next_r.fill = fillAfterPop + {1'b0, push};

    // response watchdog and total probe time
    // the watchdog restarts on every answer, so a slow but live memory
    // is kept; the budget only runs while memory pins are driven and
    // is never cleared before reset, so it bounds the whole walk
    if (memReq.valid && !memRsp.valid) begin
      next_r.waitCnt = r.waitCnt + 32'h1;
    end else begin
      next_r.waitCnt = '0;
    end
    if (probing) begin
      next_r.budget = r.budget + 32'h1;
    end
    if (got) begin
      next_r.word = word;
      next_r.cnt  = r.cnt + 16'h1;
    end

    unique case (r.st)
      S_IDLE: next_r.st = S_SETUP;
      S_SETUP: begin
        next_r.cnt        = '0;
        next_r.base       = '0;
        next_r.useEccFlag = 1'b0;  // first page read without ecc
        next_r.sect1024   = 1'b0;
        next_r.st = (r.src == SRC_NAND) ? S_HDR : S_VEC;
      end
      S_HDR: if (got && lastByte) begin
        next_r.cnt = '0;
        if (word[31:28] == HDR_KEY) begin
          next_r.useEccFlag = word[0];
          next_r.sect1024   = (word[17:16] == HDR_SECT_1024);
          next_r.base       = NAND_CODE_OFS;
          next_r.st         = S_VEC;
        end else begin
          next_r.st = S_ID;
        end
      end
      S_ID: if (got && lastByte) begin
        next_r.cnt  = '0;
        next_r.base = PP_PAGE_OFS;
        next_r.st   = (word == ONFI_SIG) ? S_PARAM : S_RESTORE;
      end
      S_PARAM: if (got) begin
        // capture fields as the page streams past
        unique case (memReq.addr)
          PP_PAGE_OFS:         next_r.pageSize[7:0]   = memRsp.data;
          PP_PAGE_OFS + 16'h1: next_r.pageSize[15:8]  = memRsp.data;
          PP_SPARE_OFS:        next_r.spareSize[7:0]  = memRsp.data;
          PP_SPARE_OFS + 16'h1:next_r.spareSize[15:8] = memRsp.data;
          default: ;
        endcase
        if (memReq.addr == PP_ECC_OFS) begin
          next_r.eccBits    = memRsp.data;
          next_r.sect1024   = (memRsp.data == ECC_CAP_WIDE);
          next_r.useEccFlag = 1'b1;
          next_r.base       = NAND_CODE_OFS;
          next_r.cnt        = '0;
          next_r.st         = S_VEC;
        end
      end
      S_VEC: if (got && lastByte) begin
        if (r.cnt[15:2] == VEC6_OFS[15:2]) begin
          vecBad        = (word >= IMG_MAX);
          next_r.imgLen = word[15:0];
        end else begin
          vecBad = ((word & BRANCH_MASK) != BRANCH_OPC)
                && ((word & LDR_MASK) != LDR_OPC);
        end
        if (vecBad) begin
          next_r.st = S_RESTORE;
        end else if (r.cnt == VEC_BYTES - 16'h1) begin
          next_r.cnt = '0;
          next_r.st  = S_COPY;
        end
      end
      S_COPY: if (r.cnt == r.imgLen) begin
        next_r.st = S_DRAIN;
      end
      S_DRAIN: if (r.fill == 2'h0) begin
        next_r.st = S_RELEASE;
      end
      S_RELEASE: next_r.st = S_JUMP;
      S_JUMP: next_r.st = S_JUMP;
      S_RESTORE: begin
        if (r.src == SRC_TWI || r.giveUp) begin
          next_r.st = S_MON;
        end else begin
          next_r.src = nbps_src_e'(3'(r.src + 3'h1));
          next_r.st  = S_SETUP;
        end
      end
      S_MON: begin
        if (r.usbSync[1]) begin
          next_r.iface = IF_USB;
          next_r.st    = S_LOOP;
        end else if (r.dbgSync[1]) begin
          next_r.iface = IF_DEBUG_SERIAL;
          next_r.st    = S_LOOP;
        end
      end
      S_LOOP: next_r.st = S_LOOP;
      default: next_r.st = S_IDLE;
    endcase

    // engine error or silent memory abandons the source
    if (reading && ((memReq.valid && memRsp.valid && memRsp.err)
        || r.waitCnt == RESP_TIMEOUT - 1)) begin
      next_r.st = S_RESTORE;
    end
    // whole probe walk stays under one second of pin drive
    if (probing && r.budget == PROBE_BUDGET - 1) begin
      next_r.giveUp = 1'b1;
      next_r.st     = S_RESTORE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  // everything, the synchronisers and the sram buffer included, sits in
  // one record; reset clears it all, which parks the sequencer in idle
  // with no port driven and the first source selected
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin ownership, port resets and monitor status
  // only the port of the source under test is driven while probing, and the monitor port in monitor and loop; restore and
  // release show the reset pulse with the pins already let go
  always_comb begin
    pinDrive  = '0;
    portReset = '0;
    if (probing) begin
      pinDrive[portOf(r.src)] = 1'b1;
    end
    if (r.st == S_RESTORE || r.st == S_RELEASE) begin
      portReset[portOf(r.src)] = 1'b1;
    end
    if (r.st == S_MON || r.st == S_LOOP) begin
      pinDrive[PORT_MON] = 1'b1;
    end
  end

  // sram side of the buffer and status outputs
  assign sramValid    = (r.fill != 2'h0);
  assign sramWr       = r.buffer[0];
  assign monitorInit  = (r.st == S_MON);
  assign monitorRun   = (r.st == S_LOOP);
  assign monitorIface = r.iface;
  assign bootDone     = (r.st == S_JUMP);
  assign eccVecAddr   = ROM_ECC_VEC_ADDR;

endmodule

// ==== dv/nbps_sequencer_properties.sv ====
// nbps_sequencer_properties: port checks of the boot probe sequencer
// assumes a bind onto nbps_sequencer, its counts handed on as parameters
`timescale 1ns/1ps
module nbps_sequencer_properties
  import nbps_pkg::*;
#(
  parameter int unsigned RESP_TIMEOUT = 16,
  parameter int unsigned PROBE_BUDGET = 2000
) (
  input wire logic        clock,         // system clock
  input wire logic        rst,           // synchronous reset
  input wire nbps_req_s   memReq,        // byte request
  input wire nbps_rsp_s   memRsp,        // byte answer
  input wire logic        sramValid,     // sram byte offered
  input wire nbps_sram_s  sramWr,        // sram address and byte
  input wire logic        sramReady,     // sram takes byte
  input wire logic [4:0]  pinDrive,      // port pins in use
  input wire logic        usbEnumerated, // usb seen
  input wire logic        debugRxSeen,   // debug char seen
  input wire logic        monitorInit,   // monitor waiting
  input wire logic        monitorRun,    // monitor loop
  input wire nbps_iface_e monitorIface,  // chosen link
  input wire logic        bootDone,      // jump taken
  input wire logic [31:0] eccVecAddr     // rom ecc vector
);
  int unsigned waitCnt;
  int unsigned pinCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // unanswered wait and memory pin time since reset
  always_ff @(posedge clock) begin
    waitCnt <= (rst || !memReq.valid || memRsp.valid) ? 0 : waitCnt + 1;
    pinCnt <= rst ? 0 : pinCnt + 32'(pinDrive[3:0] != 4'h0);
  end
  sequence s_usb_held;
    (monitorInit && usbEnumerated) [*3];
  endsequence
  sequence s_dbg_held;
    (monitorInit && debugRxSeen && !usbEnumerated) [*3];
  endsequence
  a_req_held: assert property (memReq.valid && !memRsp.valid &&
    waitCnt + 4 < RESP_TIMEOUT |=> memReq.valid && $stable(memReq.addr))
    else $error("request dropped before answer");
  a_wait_bound: assert property (waitCnt <= RESP_TIMEOUT)
    else $error("request waited past timeout");
  a_sram_hold: assert property (sramValid && !sramReady |=>
    sramValid && $stable(sramWr)) else $error("sram byte lost");
  a_paged_opcode: assert property (memReq.valid &&
    memReq.src == SRC_SPI_PAGED |-> memReq.opcode == SPI_OP_PAGED)
    else $error("paged flash opcode wrong");
  a_generic_opcode: assert property (memReq.valid &&
    memReq.src == SRC_SPI_GENERIC |-> memReq.opcode == SPI_OP_GENERIC)
    else $error("generic flash opcode wrong");
  a_id_request: assert property ($rose(memReq.valid &&
    memReq.op == OP_ID) |-> memReq.opcode == NAND_ID_OPCODE &&
    memReq.addr == NAND_ID_ADDR) else $error("nand id request wrong");
  a_eeprom_addr: assert property (memReq.valid &&
    memReq.src == SRC_TWI |-> memReq.devAddr == EEPROM_DEV_ADDR)
    else $error("eeprom device address wrong");
  a_ecc_vector: assert property (eccVecAddr == ROM_ECC_VEC_ADDR)
    else $error("ecc vector address wrong");
  a_boot_clean: assert property ($rose(bootDone) |->
    pinDrive == 5'h00 ##1 bootDone) else $error("pins held at jump");
  a_usb_pick: assert property (s_usb_held |=>
    monitorRun && monitorIface == IF_USB) else $error("usb not chosen");
  a_dbg_pick: assert property (s_dbg_held |=>
    monitorRun && monitorIface == IF_DEBUG_SERIAL)
    else $error("debug serial not chosen");
  a_mon_stay: assert property (monitorRun |=>
    monitorRun && $stable(monitorIface)) else $error("monitor left");
  a_pin_budget: assert property (pinCnt <= PROBE_BUDGET)
    else $error("memory pins driven too long");
endmodule

// ==== dv/nbps_mem_model.sv ====
// nbps_mem_model: the boot memories behind the byte request port
// assumes the bench fills img and picks latency and absent sources
`timescale 1ns/1ps
module nbps_mem_model
  import nbps_pkg::*;
(
  input  wire logic       clock,   // system clock
  input  wire nbps_req_s  memReq,  // byte request
  input  wire logic [1:0] lat,     // idle cycles before answer
  input  wire logic [4:0] absent,  // sources that never answer
  output nbps_rsp_s       memRsp   // byte answer pulse
);
  logic [7:0] img [int];
  logic [1:0] cnt = 2'h0;
  logic [1:0] idx = 2'h0;
  initial memRsp = '0;
  ////////////////////////////////////////////////////////////////////////
  // one pulse per byte; released data shows the inverse
  always @(posedge clock) begin
    if (memRsp.valid) begin
      memRsp.valid <= 1'b0;
      memRsp.data <= ~memRsp.data;
      cnt <= 2'h0;
    end else if (memReq.valid && !absent[memReq.src]) begin
      if (cnt >= lat) begin
        memRsp.valid <= 1'b1;
        idx <= (memReq.op == OP_ID) ? idx + 2'h1 : 2'h0;
        if (memReq.op == OP_ID)
          memRsp.data <= ONFI_SIG[8 * idx +: 8];
        else if (img.exists({memReq.src, memReq.op, memReq.addr}))
          memRsp.data <= img[{memReq.src, memReq.op, memReq.addr}];
        else
          memRsp.data <= 8'hFF; // erased memory
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// ==== dv/tb_nbps_sequencer.sv ====
// tb_nbps_sequencer: boots from each source, then falls to the monitor
// assumes nbps_mem_model stands in for all boot memories
`timescale 1ns/1ps
module tb_nbps_sequencer;
  import nbps_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  nbps_req_s   memReq;
  nbps_rsp_s   memRsp;
  logic        sramValid;
  nbps_sram_s  sramWr;
  logic        sramReady = 1'b1;
  logic [4:0]  pinDrive;
  logic [4:0]  portReset;
  logic        usbEnumerated = 1'b0;
  logic        debugRxSeen = 1'b0;
  logic        monitorInit;
  logic        monitorRun;
  nbps_iface_e monitorIface;
  logic        bootDone;
  logic [31:0] eccVecAddr;
  logic [1:0]  lat = 2'h0;
  logic [4:0]  absent = 5'h1F;
  int          n_fail = 0;
  int          total_checks = 0;
  int          seed = 32'he01a92f6;
  logic [7:0]  exp[$];
  nbps_sram_s  got[$];
  logic        eccSeen;
  logic [10:0] sectSeen;
  logic [4:0]  lastReset;
  nbps_sequencer #(.RESP_TIMEOUT(16), .PROBE_BUDGET(4000))
    nbps_sequencer_inst (.clock, .rst, .memReq, .memRsp, .sramValid,
    .sramWr, .sramReady, .pinDrive, .portReset, .usbEnumerated,
    .debugRxSeen, .monitorInit, .monitorRun, .monitorIface, .bootDone,
    .eccVecAddr);
  nbps_mem_model nbps_mem_model_inst (.clock, .memReq, .lat, .absent,
    .memRsp);
  ////////////////////////////////////////////////////////////////////////
  // clock, sram stalls and capture of sram writes and nand reads
  always #5 clock = ~clock;
  always @(negedge clock) sramReady <= 1'($random(seed));
  always @(posedge clock) begin
    if (!rst && sramValid && sramReady)
      got.push_back(sramWr);
    if (!rst && portReset != 5'h00)
      lastReset <= portReset;
    if (memReq.valid && memReq.src == SRC_NAND && memReq.op == OP_READ &&
        memReq.addr >= NAND_CODE_OFS) begin
      eccSeen <= memReq.useEccFlag;
      sectSeen <= memReq.eccSector;
    end
  end
  // vector word: branch or pc load, sixth holds the length
  function automatic logic [31:0] vec(int i, int len, logic [31:0] r);
    if (i == 5)
      return 32'(len);
    return i[0] ? {20'hE59FF, r[11:0]} : {8'hEA, r[23:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic load(input logic [2:0] s, input logic [1:0] o,
                      input int base, input int len, input int size);
    logic [31:0] w;
    logic [7:0]  b;
    exp.delete();
    for (int i = 0; i < len; i++) begin
      if (i % 4 == 0)
        w = vec(i / 4, size, $random(seed));
      b = (i < 28) ? w[8 * (i % 4) +: 8] : 8'($random(seed));
      nbps_mem_model_inst.img[{s, o, 16'(base + i)}] = b;
      exp.push_back(b);
    end
  endtask
  task automatic go(input logic [4:0] abs, input logic wantBoot,
                    input logic [4:0] wantReset);
    int i;
    absent = abs;
    lat = 2'($random(seed));
    usbEnumerated = 1'b0;
    debugRxSeen = 1'b0;
    rst = 1'b1;
    repeat (5) @(negedge clock);
    got.delete();
    lastReset = 5'h00;
    rst = 1'b0;
    for (i = 0; i < 6000 && bootDone !== 1'b1 && monitorInit !== 1'b1; i++)
      @(negedge clock);
    if (i == 6000) begin
      n_fail++;
      $display("BAD %0t no boot and no monitor", $time);
      conclude();
    end
    chk(bootDone, wantBoot);
    chk(monitorInit, !wantBoot);
    chk(pinDrive[3:0], 4'h0);
    chk(lastReset, wantReset);
    chk(got.size(), wantBoot ? exp.size() : 0);
    foreach (got[k]) begin
      chk(got[k].addr, k);
      chk(got[k].data, exp[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [2:0] src [4] = '{SRC_SPI_GENERIC, SRC_SPI_PAGED, SRC_SD, SRC_TWI};
    logic [1:0] op [4] = '{OP_READ, OP_READ, OP_FILE, OP_READ};
    int         len;
    // good image at one source, earlier ones erased, later ones absent
    for (int j = 0; j < 4; j++) begin
      nbps_mem_model_inst.img.delete();
      len = 28 + ($random(seed) & 63);
      load(src[j], op[j], 0, len, len);
      go(5'h1F & ~((5'h02 << src[j]) - 5'h01), 1'b1,
         (j == 3) ? 5'h08 : (j == 2) ? 5'h02 : 5'h01);
    end
    chk(eccVecAddr, ROM_ECC_VEC_ADDR);
    // nand header with ecc flag clear, then open nand ecc 8 and 0xFF
    for (int k = 0; k < 3; k++) begin
      nbps_mem_model_inst.img.delete();
      len = 28 + ($random(seed) & 63);
      load(SRC_NAND, OP_READ, NAND_CODE_OFS, len, len);
      for (int b = 0; b < 4 && k == 0; b++)
        nbps_mem_model_inst.img[{SRC_NAND, OP_READ, 16'(b)}] =
          8'(32'hC001_0000 >> (8 * b));
      nbps_mem_model_inst.img[{SRC_NAND, OP_PARAM, PP_ECC_OFS}] =
        (k == 2) ? ECC_CAP_WIDE : 8'h08;
      go(5'h17, 1'b1, 5'h04);
      chk(eccSeen, k != 0);
      if (k != 0)
        chk(sectSeen, (k == 2) ? SECT_1024 : SECT_512);
    end
    // oversize image is refused, then the monitor link is chosen
    for (int k = 0; k < 2; k++) begin
      nbps_mem_model_inst.img.delete();
      load(SRC_SPI_GENERIC, OP_READ, 0, 28, 32'h6000);
      go(5'h1E, 1'b0, 5'h08);
      debugRxSeen = 1'b1;
      usbEnumerated = 1'(k);
      repeat (3) @(negedge clock);
      chk(monitorRun, 1'b1);
      chk(pinDrive, 5'h10);
      chk(monitorIface, k ? IF_USB : IF_DEBUG_SERIAL);
      usbEnumerated = 1'(!k);
      repeat (20) @(negedge clock);
      chk(monitorIface, k ? IF_USB : IF_DEBUG_SERIAL);
    end
    conclude();
  end
endmodule
bind nbps_sequencer nbps_sequencer_properties #(
  .RESP_TIMEOUT(RESP_TIMEOUT), .PROBE_BUDGET(PROBE_BUDGET))
  nbps_sequencer_properties_inst (.clock, .rst, .memReq, .memRsp,
  .sramValid, .sramWr, .sramReady, .pinDrive, .usbEnumerated,
  .debugRxSeen, .monitorInit, .monitorRun, .monitorIface, .bootDone,
  .eccVecAddr);
